// ===== dmau_crc32.sv
`timescale 1ns/1ps
`default_nettype none
module dmau_crc32 import dmau_pkg::*; (
  // running value and memory word
  input wire logic [31:0] crc_in,
  input wire logic [31:0] data_word,
  // folded value
  output logic [31:0] crc_out
);

  // bytes in address order (msb lane first), each byte lsb first
  always_comb begin : fold
    crc_out = crc_in;
    for (int i = 0; i < 32; i++) begin
      if (crc_out[0] ^ data_word[24 - 8 * (i / 8) + (i % 8)]) begin
        crc_out = (crc_out >> 1) ^ CRC_POLY_REFL;
      end else begin
        crc_out = crc_out >> 1;
      end
    end
  end

endmodule // dmau_crc32
`default_nettype wire

// ===== dmau_lane.sv
`timescale 1ns/1ps
`default_nettype none
module dmau_lane import dmau_pkg::*; (
  // access shape
  input wire logic [2:0] size_field,
  input wire logic [1:0] rd_lane,
  input wire logic [1:0] wr_lane,
  // data in
  input wire logic [31:0] mem_word,
  input wire logic [31:0] reg_word,
  // data out
  output logic [31:0] rd_data,
  output logic [31:0] wr_data,
  output logic [3:0] wr_be
);

  // memory word is big-endian: lowest address in bits 31:24
  wire logic [4:0] rd_shift;
  wire logic [31:0] rd_shifted;
  wire logic is_byte;
  wire logic is_half;

  assign is_byte = size_field == SZ_BYTE;
  assign is_half = size_field == SZ_HALF;
  assign rd_shift = {2'h3 - rd_lane, 3'h0};
  assign rd_shifted = mem_word >> rd_shift;

  // register side is right aligned
  assign rd_data = is_byte ? {24'h00_0000, rd_shifted[7:0]} :
                   is_half ? {16'h0000, (rd_lane[1] ? mem_word[15:0] : mem_word[31:16])} :
                   mem_word;
  assign wr_data = is_byte ? {4{reg_word[7:0]}} :
                   is_half ? {2{reg_word[15:0]}} :
                   reg_word;
  assign wr_be = is_byte ? (4'h8 >> wr_lane) :
                 is_half ? (wr_lane[1] ? 4'h3 : 4'hc) :
                 4'hf;

endmodule // dmau_lane
`default_nettype wire

// ===== dmau_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module dmau_mem_model import dmau_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // data cache port
  input wire dmau_mem_req_t mem_req,
  output dmau_mem_rsp_t mem_rsp,
  // latency and fault control
  input wire logic [3:0] lat,
  input wire logic err_on,
  input wire logic [31:0] err_addr
);
  logic [31:0] mem [0:63];
  logic [3:0] wait_r;
  logic last_cached;
  logic hit;
  logic bad;
  assign hit = mem_req.valid && !mem_rsp.ack && wait_r == lat;
  assign bad = err_on && mem_req.addr == err_addr;
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      mem_rsp <= '0;
      wait_r <= 4'h0;
      last_cached <= 1'b0;
      // byte at address a holds a, big-endian lanes; one writer for the array
      for (int i = 0; i < 64; i++) begin
        mem[i] <= {i[5:0], 2'h0, i[5:0], 2'h1, i[5:0], 2'h2, i[5:0], 2'h3};
      end
    end else begin
      mem_rsp.ack <= hit;
      mem_rsp.err <= hit && bad;
      // idle bus toggles so a stale word never passes for a fresh one
      mem_rsp.rdata <= hit ? mem[mem_req.addr[7:2]] : ~mem_rsp.rdata;
      wait_r <= (mem_req.valid && !hit && !mem_rsp.ack) ? wait_r + 4'h1 : 4'h0;
      if (hit) begin
        last_cached <= mem_req.cached;
      end
      if (hit && mem_req.write && !bad) begin
        for (int b = 0; b < 4; b++) begin
          if (mem_req.be[b]) begin
            mem[mem_req.addr[7:2]][8*b +: 8] <= mem_req.wdata[8*b +: 8];
          end
        end
      end
    end
  end
endmodule // dmau_mem_model
`default_nettype wire

// ===== dmau_pkg.sv
`default_nettype none
package dmau_pkg;

  // register indices on the debug port
  localparam logic [6:0] IDX_CS = 7'h07;
  localparam logic [6:0] IDX_ADDR = 7'h09;
  localparam logic [6:0] IDX_DATA = 7'h0a;

  // control/status layout, msb first
  typedef struct packed {
    logic access_go;
    logic dir;
    logic [2:0] size_field;
    logic [1:0] cache_path_select;
    logic wrapped;
    logic trace_region_guard;
    logic trace_buffer_enable;
    logic [1:0] buffer_full_policy;
    logic crc_en;
    logic [2:0] rsvd;
    logic [13:0] access_count;
    logic err;
    logic data_valid_flag;
  } dmau_cs_t;

  localparam logic [31:0] CS_RESET = 32'h0000_0000;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;

  // size, cache path and buffer full codes
  localparam logic [2:0] SZ_BYTE = 3'h0;
  localparam logic [2:0] SZ_HALF = 3'h1;
  localparam logic [2:0] SZ_WORD = 3'h2;
  localparam logic [1:0] CC_AUTO = 2'h0;
  localparam logic [1:0] CC_CACHED = 2'h1;
  localparam logic [1:0] CC_UNCACHED = 2'h2;
  localparam logic [1:0] POL_OVERWRITE = 2'h0;
  localparam logic [1:0] POL_DISABLE = 2'h1;
  localparam logic [1:0] POL_BREAK = 2'h2;

  // address steps and trace window
  localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
  localparam logic [31:0] STEP_HALF = 32'h0000_0002;
  localparam logic [31:0] STEP_WORD = 32'h0000_0004;
  localparam logic [4:0] TRACE_EXP_LSB = 5'h02;

  // ethernet crc-32, reflected form
  localparam logic [31:0] CRC_POLY_REFL = 32'hedb8_8320;
  localparam logic [31:0] CRC_INIT = 32'hffff_ffff;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] idx;
    logic [31:0] wdata;
  } dmau_dbg_req_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic cached;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
  } dmau_mem_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
  } dmau_mem_rsp_t;

  typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_REQ} dmau_state_t;

endpackage
`default_nettype wire

// ===== dmau_top.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// [R1] go bit starts access, clears when finished
// [R2] control write aborts; go restarts fresh
// [R3] direction bit: 0 read, 1 write
// [R4] size codes byte, half, word only
// [R5] cache path: auto, cached, uncached
// [R6] auto with trace writes cached view
// [R7] cached view errors leave error clear
// [R8] uncached view errors set error flag
// [R9] wrap flag sets on trace pointer wrap
// [R10] trace enable and region guard bits
// [R11] full policy: overwrite, disable, break
// [R12] checksum reads block, result in data
// [R13] no checksum with trace, word size; code checks neither trace enable nor size field when checksum is on
// [R14] count increments, move ends at wrap
// [R15] error keeps count progress
// [R16] abort on bus, control, zero count
// [R17] valid/error status pair encoding
// [R18] data read clears valid on reads
// [R19] address is lowest, msb byte address
// [R20] data right aligned little endian; code keeps big-endian byte order, lowest address in the upper bits
// [R21] data holds write source, read result
// [R22] no messages, plain register access
// [R23] trace setup: write, word, exponent
// [R24] disable policy clears enable, go, valid
// [R25] ethernet crc-32 polynomial
// [R26] address steps by access size
module dmau_top import dmau_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // debug port register access
  input wire dmau_dbg_req_t dbg_req,
  output logic [31:0] dbg_rdata,
  output logic dbg_rvalid,
  // data cache port
  output dmau_mem_req_t mem_req,
  input wire dmau_mem_rsp_t mem_rsp,
  // trace word stream
  input wire logic trace_valid,
  input wire logic [31:0] trace_word,
  output logic trace_ready,
  // trace region and buffer status to core
  output logic trace_guard_en,
  output logic [31:0] trace_guard_base,
  output logic [31:0] trace_guard_mask,
  output logic trace_full_break
);

  dmau_cs_t cs_r, cs_nxt;
  logic [31:0] addr_r, addr_nxt;
  logic [31:0] data_r, data_nxt;
  logic [31:0] crc_r, crc_nxt;
  dmau_state_t state_r, state_nxt;
  dmau_mem_req_t mreq_nxt;
  logic drop_r, drop_nxt;
  logic fresh_r, fresh_nxt;
  logic chain_r, chain_nxt;
  logic brk_nxt;
  logic [31:0] rdata_nxt;

  // register decode
  wire logic cs_wr;
  wire logic addr_wr;
  wire logic data_wr;
  wire logic data_rd;
  wire dmau_cs_t wcs;

  assign cs_wr = dbg_req.wr && dbg_req.idx == IDX_CS;
  assign addr_wr = dbg_req.wr && dbg_req.idx == IDX_ADDR;
  assign data_wr = dbg_req.wr && dbg_req.idx == IDX_DATA;
  assign data_rd = dbg_req.rd && dbg_req.idx == IDX_DATA;
  assign wcs = dmau_cs_t'(dbg_req.wdata);

  // mode decode
  wire logic busy;
  wire logic trace_mode;
  wire logic is_write;
  wire logic view_cached;
  wire logic single;
  wire logic [31:0] step;

  assign busy = cs_r.access_go;
  assign trace_mode = cs_r.trace_buffer_enable;
  assign is_write = cs_r.dir | trace_mode; // [R3]
  // auto: cached reads, uncached writes, trace always cached
  assign view_cached = (cs_r.cache_path_select == CC_CACHED) ? 1'b1 :
                       (cs_r.cache_path_select == CC_UNCACHED) ? 1'b0 :
                       (~cs_r.dir | trace_mode); // [R5] [R6]
  assign single = cs_r.access_count == 14'h0000;
  // reserved size codes fall back to word steps
  assign step = (cs_r.size_field == SZ_BYTE) ? STEP_BYTE :
                (cs_r.size_field == SZ_HALF) ? STEP_HALF : STEP_WORD; // [R4] [R26]

  // circular trace pointer, window 2^(n+2) bytes
  wire logic [4:0] trace_shift;
  wire logic [31:0] trace_mask;
  wire logic [31:0] trace_low;
  wire logic [31:0] trace_next_addr;
  wire logic trace_wrap;

  assign trace_shift = cs_r.access_count[4:0];
  assign trace_mask = (STEP_WORD << trace_shift) - STEP_BYTE;
  assign trace_low = (addr_r + STEP_WORD) & trace_mask;
  assign trace_next_addr = (addr_r & ~trace_mask) | trace_low;
  assign trace_wrap = trace_low == 32'h0000_0000;

  wire logic [13:0] cnt_inc;
  assign cnt_inc = cs_r.access_count + 14'h0001;

  // handshakes with memory and trace source
  wire logic go_ok;
  wire logic issue;
  wire logic rsp_take;
  wire logic rsp_use;
  wire logic rsp_err;
  wire logic rsp_ok;
  wire logic last;
  wire logic rd_done;
  wire logic crc_done;
  wire logic dv_set;

  // block reads wait for the previous word to be read out
  assign go_ok = trace_mode ? trace_valid : (cs_r.dir ? fresh_r : ~cs_r.data_valid_flag);
  assign issue = state_r == ST_HOLD && busy && go_ok && !cs_wr;
  assign trace_ready = issue && trace_mode;
  assign rsp_take = state_r == ST_REQ && mem_rsp.ack;
  // a control write in the ack cycle discards the answer
  assign rsp_use = rsp_take && !drop_r && !cs_wr;
  assign rsp_err = rsp_use && mem_rsp.err && !mem_req.cached; // [R7] [R8]
  assign rsp_ok = rsp_use && !rsp_err;
  assign last = trace_mode ? (trace_wrap && cs_r.buffer_full_policy != POL_OVERWRITE) :
                (single || cnt_inc == 14'h0000); // [R14]
  assign rd_done = rsp_ok && !is_write && !cs_r.crc_en;
  assign crc_done = rsp_ok && cs_r.crc_en && last;
  assign dv_set = rd_done || crc_done;

  wire logic [31:0] lane_rdata;
  wire logic [31:0] lane_wdata;
  wire logic [3:0] lane_be;
  wire logic [31:0] crc_fold;

  dmau_lane u_lane (
    .size_field(cs_r.size_field),
    .rd_lane(mem_req.addr[1:0]),
    .wr_lane(addr_r[1:0]),
    .mem_word(mem_rsp.rdata),
    .reg_word(data_r),
    .rd_data(lane_rdata),
    .wr_data(lane_wdata),
    .wr_be(lane_be)
  );

  dmau_crc32 u_crc (
    .crc_in(crc_r),
    .data_word(mem_rsp.rdata),
    .crc_out(crc_fold)
  );

  always_comb begin
    cs_nxt = cs_r;
    addr_nxt = addr_r;
    data_nxt = data_r;
    crc_nxt = crc_r;
    state_nxt = state_r;
    mreq_nxt = mem_req;
    drop_nxt = drop_r;
    fresh_nxt = fresh_r;
    chain_nxt = chain_r;
    brk_nxt = 1'b0;
    // debugger data and address writes
    if (addr_wr) begin
      addr_nxt = dbg_req.wdata;
    end
    if (data_wr) begin
      data_nxt = dbg_req.wdata; // [R21]
      fresh_nxt = 1'b1;
    end
    if (data_rd && !cs_r.dir) begin
      cs_nxt.data_valid_flag = 1'b0; // [R18]
    end
    // issue one access
    if (issue) begin
      mreq_nxt.valid = 1'b1;
      mreq_nxt.write = is_write;
      mreq_nxt.cached = view_cached;
      mreq_nxt.addr = addr_r;
      mreq_nxt.wdata = trace_mode ? trace_word : lane_wdata; // [R20]
      mreq_nxt.be = trace_mode ? 4'hf : lane_be;
      state_nxt = ST_REQ;
      fresh_nxt = 1'b0;
      if (trace_mode) begin
        data_nxt = trace_word;
      end
    end
    if (rsp_take) begin
      mreq_nxt.valid = 1'b0;
      drop_nxt = 1'b0;
      state_nxt = busy ? ST_HOLD : ST_IDLE;
    end
    // bus error: stop, count keeps its progress
    if (rsp_err) begin
      cs_nxt.access_go = 1'b0;
      cs_nxt.err = 1'b1; // [R8] [R15] [R16]
      cs_nxt.data_valid_flag = 1'b0;
      state_nxt = ST_IDLE;
    end
    if (rsp_ok) begin
      if (rd_done) begin
        data_nxt = lane_rdata; // [R20] [R21]
        cs_nxt.data_valid_flag = 1'b1;
      end
      if (cs_r.crc_en) begin
        crc_nxt = crc_fold; // [R12]
      end
      if (trace_mode) begin
        addr_nxt = trace_next_addr;
        if (trace_wrap) begin
          cs_nxt.wrapped = 1'b1; // [R9]
        end
      end else if (!single) begin
        addr_nxt = addr_r + step; // [R26]
        cs_nxt.access_count = cnt_inc; // [R14]
      end
      if (last) begin
        cs_nxt.access_go = 1'b0; // [R1]
        state_nxt = ST_IDLE;
        if (trace_mode) begin
          cs_nxt.data_valid_flag = 1'b0; // [R11] [R24]
          if (cs_r.buffer_full_policy == POL_DISABLE) begin
            cs_nxt.trace_buffer_enable = 1'b0;
          end
          brk_nxt = cs_r.buffer_full_policy == POL_BREAK;
        end else if (is_write) begin
          cs_nxt.data_valid_flag = 1'b0; // [R17]
        end
        if (crc_done) begin
          data_nxt = ~crc_fold; // [R12] [R25]
          cs_nxt.data_valid_flag = 1'b1;
          chain_nxt = 1'b1;
        end
      end
    end
    // control write aborts whatever runs, then reloads
    if (cs_wr) begin
      cs_nxt = wcs;
      cs_nxt.rsvd = 3'h0;
      cs_nxt.err = busy && !wcs.access_go; // [R2] [R16]
      cs_nxt.data_valid_flag = 1'b0;
      if (wcs.access_go) begin
        if (wcs.crc_en && wcs.access_count == 14'h0000) begin
          cs_nxt.access_go = 1'b0; // [R16]
          cs_nxt.err = 1'b1;
        end else begin
          // write pending shows as valid until done
          cs_nxt.data_valid_flag = wcs.dir && !wcs.trace_buffer_enable; // [R17]
          fresh_nxt = 1'b1;
          chain_nxt = 1'b0;
          if (!(chain_r && wcs.crc_en)) begin
            crc_nxt = CRC_INIT; // [R12]
          end
        end
      end
      // an outstanding request must still drain its ack
      if (state_r == ST_REQ && !mem_rsp.ack) begin
        drop_nxt = 1'b1; // [R2]
      end else begin
        state_nxt = cs_nxt.access_go ? ST_HOLD : ST_IDLE;
      end
    end
  end

  // register read mux, unmapped reads as zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (dbg_req.idx == IDX_CS) begin
      rdata_nxt = cs_r; // [R22]
    end else if (dbg_req.idx == IDX_ADDR) begin
      rdata_nxt = addr_r;
    end else if (dbg_req.idx == IDX_DATA) begin
      rdata_nxt = data_r;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cs_r <= dmau_cs_t'(CS_RESET);
      addr_r <= ADDR_RESET;
      data_r <= DATA_RESET;
      crc_r <= CRC_INIT;
      state_r <= ST_IDLE;
      mem_req <= '0;
      drop_r <= 1'b0;
      fresh_r <= 1'b0;
      chain_r <= 1'b0;
    end else begin
      cs_r <= cs_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      crc_r <= crc_nxt;
      state_r <= state_nxt;
      mem_req <= mreq_nxt;
      drop_r <= drop_nxt;
      fresh_r <= fresh_nxt;
      chain_r <= chain_nxt;
    end
  end

  // status outputs registered so the core sees clean levels
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dbg_rdata <= DATA_RESET;
      dbg_rvalid <= 1'b0;
      trace_guard_en <= 1'b0;
      trace_guard_base <= ADDR_RESET;
      trace_guard_mask <= ADDR_RESET;
      trace_full_break <= 1'b0;
    end else begin
      dbg_rvalid <= dbg_req.rd;
      if (dbg_req.rd) begin
        dbg_rdata <= rdata_nxt;
      end
      trace_guard_en <= cs_r.trace_buffer_enable && cs_r.trace_region_guard; // [R10]
      trace_guard_base <= addr_r & ~trace_mask;
      trace_guard_mask <= trace_mask;
      trace_full_break <= brk_nxt; // [R11]
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_abort_on_write: assert property ( // [R2]
    cs_wr && busy && !wcs.access_go |=> !cs_r.access_go && cs_r.err && !cs_r.data_valid_flag)
    else $error("control write did not abort access");

  a_go_cleared: assert property ( // [R1]
    rsp_ok && last |=> !cs_r.access_go && state_r == ST_IDLE)
    else $error("go bit not cleared after last access");

  a_dir_select: assert property ( // [R3]
    $rose(mem_req.valid) && !trace_mode |-> mem_req.write == cs_r.dir)
    else $error("access direction differs from direction bit");

  a_view_forced: assert property ( // [R5]
    $rose(mem_req.valid) && cs_r.cache_path_select != CC_AUTO
      |-> mem_req.cached == (cs_r.cache_path_select == CC_CACHED))
    else $error("forced cache path not honoured");

  a_cached_err_quiet: assert property ( // [R7]
    rsp_use && mem_rsp.err && mem_req.cached |=> !cs_r.err)
    else $error("cached bus error set the error flag");

  a_uncached_err: assert property ( // [R8]
    rsp_use && mem_rsp.err && !mem_req.cached |=> cs_r.err && !cs_r.access_go && state_r == ST_IDLE)
    else $error("uncached bus error not reported");

  a_count_kept: assert property ( // [R15]
    rsp_err |=> cs_r.access_count == $past(cs_r.access_count))
    else $error("count moved on an error");

  a_block_count: assert property ( // [R14]
    rsp_ok && !trace_mode && !single
      |=> cs_r.access_count == $past(cnt_inc) && addr_r == $past(addr_r) + $past(step))
    else $error("block step of count or address wrong");

  a_zero_count_err: assert property ( // [R16]
    cs_wr && wcs.access_go && wcs.crc_en && wcs.access_count == 14'h0000 |=> cs_r.err ##1 !cs_r.access_go)
    else $error("zero count checksum not refused");

  a_status_excl: assert property ( // [R17]
    !(cs_r.data_valid_flag && cs_r.err))
    else $error("valid and error both set");

  a_read_clears_dv: assert property ( // [R18]
    data_rd && !cs_r.dir && !dv_set && !cs_wr |=> !cs_r.data_valid_flag)
    else $error("data read did not clear valid");

  a_wrap_flag: assert property ( // [R9]
    rsp_ok && trace_mode && trace_wrap |=> cs_r.wrapped)
    else $error("wrap flag not set on pointer wrap");

endmodule // dmau_top
`default_nettype wire

// ===== dmau_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dmau_top_bench import dmau_pkg::*; ();
  logic clk;
  logic reset;
  dmau_dbg_req_t dbg_req;
  logic [31:0] dbg_rdata;
  logic dbg_rvalid;
  dmau_mem_req_t mem_req;
  dmau_mem_rsp_t mem_rsp;
  logic trace_valid;
  logic [31:0] trace_word;
  logic trace_ready;
  logic trace_guard_en;
  logic [31:0] trace_guard_base;
  logic [31:0] trace_guard_mask;
  logic trace_full_break;
  logic [3:0] lat;
  logic err_on;
  logic [31:0] err_addr;
  logic saw_break;
  logic [31:0] v;
  int miscompares;
  int compares;
  localparam logic [31:0] RA [3] = '{32'h11, 32'h22, 32'h30};
  localparam logic [2:0] RS [3] = '{SZ_BYTE, SZ_HALF, SZ_WORD};
  localparam logic [1:0] RC [3] = '{CC_AUTO, CC_CACHED, CC_UNCACHED};
  localparam logic [31:0] RD [3] = '{32'h11, 32'h2223, 32'h3031_3233};
  localparam logic [31:0] RK [3] = '{32'h1, 32'h1, 32'h0};
  localparam logic [31:0] WA [3] = '{32'h81, 32'h86, 32'h88};
  localparam logic [31:0] WD [3] = '{32'ha5, 32'h1234, 32'hdead_beef};
  localparam logic [31:0] WM [3] = '{32'h80a5_8283, 32'h8485_1234, 32'hdead_beef};

  dmau_top dut_u (
    .clk(clk), .reset(reset), .dbg_req(dbg_req), .dbg_rdata(dbg_rdata), .dbg_rvalid(dbg_rvalid),
    .mem_req(mem_req), .mem_rsp(mem_rsp), .trace_valid(trace_valid), .trace_word(trace_word),
    .trace_ready(trace_ready), .trace_guard_en(trace_guard_en), .trace_guard_base(trace_guard_base),
    .trace_guard_mask(trace_guard_mask), .trace_full_break(trace_full_break)
  );
  dmau_mem_model mem_u (
    .clk(clk), .reset(reset), .mem_req(mem_req), .mem_rsp(mem_rsp), .lat(lat), .err_on(err_on),
    .err_addr(err_addr)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // break pulse lasts one cycle, so it is latched here
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      saw_break <= 1'b0;
    end else if (trace_full_break === 1'b1) begin
      saw_break <= 1'b1;
    end
  end

  task automatic results();
    if (miscompares == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [6:0] idx, input logic [31:0] d);
    @(posedge clk);
    dbg_req <= '{wr: 1'b1, rd: 1'b0, idx: idx, wdata: d};
    @(posedge clk);
    dbg_req <= '0;
  endtask
  task automatic rd_reg(input logic [6:0] idx, output logic [31:0] d);
    int n;
    @(posedge clk);
    dbg_req <= '{wr: 1'b0, rd: 1'b1, idx: idx, wdata: 32'h0};
    @(posedge clk);
    dbg_req <= '0;
    for (n = 0; n < 4 && dbg_rvalid !== 1'b1; n++) @(posedge clk);
    if (n == 4) begin
      miscompares++;
      results();
    end
    d = dbg_rdata;
  endtask
  task automatic rd_chk(input logic [6:0] idx, input logic [31:0] exp);
    rd_reg(idx, v);
    check(v, exp);
  endtask
  task automatic cs_chk(input logic [31:0] mask, input logic [31:0] exp);
    rd_reg(IDX_CS, v);
    check(v & mask, exp);
  endtask
  // polls status; slow memory answers need many reads
  task automatic wait_cs(input logic [31:0] mask, input logic [31:0] val);
    for (int n = 0; n < 60; n++) begin
      rd_reg(IDX_CS, v);
      if ((v & mask) === val) return;
    end
    miscompares++;
    results();
  endtask
  task automatic send_trace(input logic [31:0] w);
    @(posedge clk);
    trace_valid <= 1'b1;
    trace_word <= w;
    for (int n = 0; n <= 20; n++) begin
      @(posedge clk);
      if (trace_ready === 1'b1) break;
      if (n == 20) begin
        miscompares++;
        results();
      end
    end
    trace_valid <= 1'b0;
  endtask
  function automatic logic [31:0] csw(logic dir, logic [2:0] sz, logic [1:0] cc, logic [13:0] cnt);
    return {1'b1, dir, sz, cc, 9'h000, cnt, 2'h0};
  endfunction
  function automatic logic [31:0] crc_bytes(logic [7:0] first, int len);
    logic [31:0] c;
    c = CRC_INIT;
    for (int i = 0; i < len; i++) begin
      c = c ^ {24'h0, first + i[7:0]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ CRC_POLY_REFL : c >> 1;
    end
    return ~c;
  endfunction

  initial begin
    reset = 1'b1;
    dbg_req = '0;
    trace_valid = 1'b0;
    trace_word = 32'h0;
    lat = 4'h1;
    err_on = 1'b0;
    err_addr = 32'h0;
    miscompares = 0;
    compares = 0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    wr_reg(7'h08, 32'hffff_ffff);
    rd_chk(7'h08, 32'h0);
    rd_chk(IDX_CS, CS_RESET);
    rd_chk(IDX_ADDR, ADDR_RESET);
    rd_chk(IDX_DATA, DATA_RESET);
    for (int i = 0; i < 3; i++) begin
      wr_reg(IDX_ADDR, RA[i]);
      wr_reg(IDX_CS, csw(1'b0, RS[i], RC[i], 14'h0));
      wait_cs(32'h8000_0000, 32'h0);
      cs_chk(32'h0000_0003, 32'h1);
      check({31'h0, mem_u.last_cached}, RK[i]);
      rd_chk(IDX_DATA, RD[i]);
      cs_chk(32'h0000_0003, 32'h0);
    end
    for (int i = 0; i < 3; i++) begin
      wr_reg(IDX_DATA, WD[i]);
      wr_reg(IDX_ADDR, WA[i]);
      wr_reg(IDX_CS, csw(1'b1, RS[i], CC_AUTO, 14'h0));
      wait_cs(32'h8000_0000, 32'h0);
      cs_chk(32'h0000_0003, 32'h0);
      check(mem_u.mem[WA[i][7:2]], WM[i]);
      check({31'h0, mem_u.last_cached}, 32'h0);
    end
    // block write: second word only goes out after a fresh data write
    wr_reg(IDX_DATA, 32'h0102_0304);
    wr_reg(IDX_ADDR, 32'h70);
    wr_reg(IDX_CS, csw(1'b1, SZ_WORD, CC_UNCACHED, 14'h3ffe));
    wr_reg(IDX_DATA, 32'h0506_0708);
    wait_cs(32'h8000_0000, 32'h0);
    cs_chk(32'h0000_ffff, 32'h0);
    check(mem_u.mem[28], 32'h0102_0304);
    check(mem_u.mem[29], 32'h0506_0708);
    err_on <= 1'b1;
    err_addr <= 32'h3c;
    wr_reg(IDX_ADDR, 32'h3c);
    wr_reg(IDX_CS, csw(1'b0, SZ_WORD, CC_CACHED, 14'h0));
    wait_cs(32'h8000_0000, 32'h0);
    cs_chk(32'h0000_0002, 32'h0);
    err_addr <= 32'h48;
    wr_reg(IDX_ADDR, 32'h40);
    wr_reg(IDX_CS, csw(1'b0, SZ_WORD, CC_UNCACHED, 14'h3ffd));
    for (int i = 0; i < 2; i++) begin
      wait_cs(32'h0000_0001, 32'h1);
      rd_chk(IDX_DATA, 32'h4041_4243 + 32'h0404_0404 * i);
    end
    wait_cs(32'h8000_0000, 32'h0);
    cs_chk(32'h0000_ffff, 32'h0000_fffe);
    // slow memory keeps the first access open across the control write
    err_on <= 1'b0;
    lat <= 4'hf;
    wr_reg(IDX_ADDR, 32'h44);
    wr_reg(IDX_CS, csw(1'b0, SZ_WORD, CC_UNCACHED, 14'h0));
    wr_reg(IDX_CS, 32'h0);
    cs_chk(32'h8000_0003, 32'h2);
    wr_reg(IDX_CS, csw(1'b0, SZ_WORD, CC_UNCACHED, 14'h0));
    wr_reg(IDX_CS, csw(1'b0, SZ_WORD, CC_UNCACHED, 14'h0));
    wait_cs(32'h8000_0000, 32'h0);
    cs_chk(32'h0000_0003, 32'h1);
    rd_chk(IDX_DATA, 32'h4445_4647);
    lat <= 4'h2;
    wr_reg(IDX_CS, csw(1'b0, SZ_WORD, CC_AUTO, 14'h0) | 32'h0008_0000);
    wait_cs(32'h8000_0000, 32'h0);
    cs_chk(32'h0000_0003, 32'h2);
    wr_reg(IDX_ADDR, 32'h50);
    wr_reg(IDX_CS, csw(1'b0, SZ_WORD, CC_AUTO, 14'h3ffe) | 32'h0008_0000);
    wait_cs(32'h8000_0000, 32'h0);
    cs_chk(32'h0000_ffff, 32'h1);
    rd_chk(IDX_DATA, crc_bytes(8'h50, 8));
    wr_reg(IDX_ADDR, 32'h58);
    wr_reg(IDX_CS, csw(1'b0, SZ_WORD, CC_AUTO, 14'h3ffe) | 32'h0008_0000);
    wait_cs(32'h8000_0000, 32'h0);
    rd_chk(IDX_DATA, crc_bytes(8'h50, 16));
    // overwrite policy: two-word window, third word lands on the first slot again
    wr_reg(IDX_ADDR, 32'h68);
    wr_reg(IDX_CS, csw(1'b1, SZ_WORD, CC_AUTO, 14'h1) | 32'h0040_0000);
    repeat (2) @(posedge clk);
    check({31'h0, trace_guard_en}, 32'h0);
    check(trace_guard_mask, 32'h7);
    for (int k = 1; k < 4; k++) send_trace(32'hbeef_0000 + k);
    cs_chk(32'h8140_0003, 32'h8140_0000);
    rd_chk(IDX_ADDR, 32'h6c);
    check(mem_u.mem[26], 32'hbeef_0003);
    check(mem_u.mem[27], 32'hbeef_0002);
    wr_reg(IDX_CS, 32'h0);
    for (int p = 1; p < 3; p++) begin
      wr_reg(IDX_ADDR, 32'h60);
      wr_reg(IDX_CS, csw(1'b1, SZ_WORD, CC_AUTO, 14'h0) | 32'h00c0_0000 | (p << 20));
      repeat (2) @(posedge clk);
      check({31'h0, trace_guard_en}, 32'h1);
      check(trace_guard_base | trace_guard_mask, 32'h63);
      send_trace(32'hcafe_0000 + p);
      wait_cs(32'h8000_0000, 32'h0);
      cs_chk(32'h8140_0003, p == 1 ? 32'h0100_0000 : 32'h0140_0000);
      check(mem_u.mem[24], 32'hcafe_0000 + p);
      check({31'h0, mem_u.last_cached}, 32'h1);
      rd_chk(IDX_ADDR, 32'h60);
    end
    check({31'h0, saw_break}, 32'h1);
    results();
  end
endmodule // dmau_top_bench
`default_nettype wire
